// >>> inc/gate_pkg.sv
package gate_pkg;
  // Register byte offsets
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATING_OFS       = 12'h100;
  localparam logic [11:0] SLEEP_GATING_OFS     = 12'h110;
  localparam logic [11:0] DEEP_GATING_OFS      = 12'h120;
  localparam logic [11:0] IRQ_STATUS_OFS       = 12'h200;
  localparam logic [11:0] IRQ_ENABLE_OFS       = 12'h204;
  localparam logic [11:0] IRQ_CLEAR_OFS        = 12'h208;

  // Gating register field positions
  localparam int CAN_BIT   = 24;
  localparam int PWM_BIT   = 20;
  localparam int ADC_BIT   = 16;
  localparam int RATE_LSB  = 8;
  localparam int RATE_W    = 4;
  localparam int HIB_BIT   = 6;
  localparam int WDT_BIT   = 3;
  localparam logic [31:0] GATE_MASK = 32'h0111_0F48;

  // Reset values
  localparam logic [31:0] DEEP_RST  = 32'h0000_0040;
  localparam logic [31:0] RUN_RST   = 32'h0000_0000;
  localparam logic [31:0] SLEEP_RST = 32'h0000_0000;

  // ADC rate codes
  localparam logic [3:0] RATE_125K = 4'h0;
  localparam logic [3:0] RATE_250K = 4'h1;
  localparam logic [3:0] RATE_500K = 4'h2;

  // Auto gating enable position in run clock config
  localparam int ACG_BIT = 27;

  // Unit indices on the unit access port
  localparam int UNITS = 5;
  localparam logic [2:0] U_CAN = 3'h0;
  localparam logic [2:0] U_PWM = 3'h1;
  localparam logic [2:0] U_ADC = 3'h2;
  localparam logic [2:0] U_HIB = 3'h3;
  localparam logic [2:0] U_WDT = 3'h4;

  // Interrupt status bits
  localparam int IRQ_W     = 3;
  localparam int EV_FAULT  = 0;
  localparam int EV_DEEP   = 1;
  localparam int EV_WAKE   = 2;

  // System power mode, one-hot
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP  = 3'b100
  } mode_t;
endpackage

// >>> core/deep_sleep_gating.sv
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module deep_sleep_gating
  import gate_pkg::*;
#(
  parameter logic [3:0] ADC_RATE_MAX = RATE_500K
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_in,
  input  wire logic        deep_in,
  input  wire logic        unit_req,
  input  wire logic [2:0]  unit_idx,
  output logic             unit_ack,
  output logic             unit_fault,
  output logic             can_clk_en,
  output logic             pwm_clk_en,
  output logic             adc_clk_en,
  output logic             hib_clk_en,
  output logic             wdt_clk_en,
  output logic [3:0]       adc_rate,
  output logic             irq
);

  // Keep writable fields, cap ADC rate code
  function automatic logic [31:0] gate_write(input logic [31:0] d);
    logic [31:0] v;
    v = d & GATE_MASK;
    if (v[RATE_LSB +: RATE_W] > ADC_RATE_MAX) begin
      v[RATE_LSB +: RATE_W] = ADC_RATE_MAX;
    end
    return v;
  endfunction

  // Unit enable vector indexed by unit number
  function automatic logic [UNITS-1:0] unit_vec(input logic [31:0] g);
    logic [UNITS-1:0] u;
    u = '0;
    u[U_CAN] = g[CAN_BIT];
    u[U_PWM] = g[PWM_BIT];
    u[U_ADC] = g[ADC_BIT];
    u[U_HIB] = g[HIB_BIT];
    u[U_WDT] = g[WDT_BIT];
    return u;
  endfunction

  // Mode pins: three stages, change when last two agree
  logic [1:0] s1_r, s2_r, s3_r, pin_r;
  logic [1:0] pin_nxt;
  mode_t      mode_r, mode_nxt;

  always_comb begin
    pin_nxt = (s2_r == s3_r) ? s3_r : pin_r;
    if (pin_r[1]) begin
      mode_nxt = MODE_DEEP;
    end else if (pin_r[0]) begin
      mode_nxt = MODE_SLEEP;
    end else begin
      mode_nxt = MODE_RUN;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r   <= 2'h0;
      s2_r   <= 2'h0;
      s3_r   <= 2'h0;
      pin_r  <= 2'h0;
      mode_r <= MODE_RUN;
    end else begin
      s1_r   <= {deep_in, sleep_in};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      pin_r  <= pin_nxt;
      mode_r <= mode_nxt;
    end
  end

  // APB slave with one wait state
  logic [31:0] run_r, sleep_r, deep_r, cfg_r;
  logic [31:0] run_nxt, sleep_nxt, deep_nxt, cfg_nxt;
  logic [IRQ_W-1:0] ien_r, ien_nxt, stat_r, stat_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt, hit, wr, acc;
  logic [IRQ_W-1:0] clr, ev;
  logic [31:0] rd;

  always_comb begin
    acc = psel & penable & ~pready;
    wr  = psel & penable & pready & pwrite & ~pslverr;
    hit = 1'b1;
    unique case (paddr)
      RUN_CLOCK_CONFIG_OFS: rd = cfg_r;
      RUN_GATING_OFS:       rd = run_r;
      SLEEP_GATING_OFS:     rd = sleep_r;
      DEEP_GATING_OFS:      rd = deep_r;
      IRQ_STATUS_OFS:       rd = {{(32-IRQ_W){1'b0}}, stat_r};
      IRQ_ENABLE_OFS:       rd = {{(32-IRQ_W){1'b0}}, ien_r};
      IRQ_CLEAR_OFS:        rd = 32'h0000_0000;
      default: begin
        rd  = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    pready_nxt  = acc;
    pslverr_nxt = acc & ~hit;
    prdata_nxt  = (acc & ~pwrite) ? rd : 32'h0000_0000;
    run_nxt   = run_r;
    sleep_nxt = sleep_r;
    deep_nxt  = deep_r;
    cfg_nxt   = cfg_r;
    ien_nxt   = ien_r;
    clr       = '0;
    if (wr) begin
      unique case (paddr)
        RUN_CLOCK_CONFIG_OFS: cfg_nxt = pwdata & (32'h1 << ACG_BIT);
        RUN_GATING_OFS:       run_nxt = gate_write(pwdata);
        SLEEP_GATING_OFS:     sleep_nxt = gate_write(pwdata);
        DEEP_GATING_OFS:      deep_nxt = gate_write(pwdata);
        IRQ_ENABLE_OFS:       ien_nxt = pwdata[IRQ_W-1:0];
        IRQ_CLEAR_OFS:        clr = pwdata[IRQ_W-1:0];
        default:              clr = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_r   <= RUN_RST;
      sleep_r <= SLEEP_RST;
      deep_r  <= DEEP_RST;
      cfg_r   <= 32'h0000_0000;
      ien_r   <= '0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      run_r   <= run_nxt;
      sleep_r <= sleep_nxt;
      deep_r  <= deep_nxt;
      cfg_r   <= cfg_nxt;
      ien_r   <= ien_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Choose gating copy by mode and auto gating
  logic        auto_gating_enable;
  logic [31:0] eff;
  always_comb begin
    auto_gating_enable = cfg_r[ACG_BIT];
    if (auto_gating_enable && mode_r == MODE_DEEP) begin
      eff = deep_r;
    end else if (auto_gating_enable && mode_r == MODE_SLEEP) begin
      eff = sleep_r;
    end else begin
      eff = run_r;
    end
  end

  // Clock enables and rate from flip-flops
  logic [UNITS-1:0] en, en_nxt;
  logic [3:0]       rate_nxt;
  always_comb begin
    en_nxt   = unit_vec(eff);
    rate_nxt = eff[RATE_LSB +: RATE_W];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en       <= '0;
      adc_rate <= RATE_125K;
    end else begin
      en       <= en_nxt;
      adc_rate <= rate_nxt;
    end
  end

  assign can_clk_en = en[U_CAN];
  assign pwm_clk_en = en[U_PWM];
  assign adc_clk_en = en[U_ADC];
  assign hib_clk_en = en[U_HIB];
  assign wdt_clk_en = en[U_WDT];

  // Unit access: ack every request, also fault when gated or index unknown
  logic ack_nxt, fault_nxt, known;
  always_comb begin
    known     = unit_idx < 3'(UNITS);
    ack_nxt   = unit_req;
    fault_nxt = unit_req & ~(known && en[unit_idx]);
  end

  // Events: fault, entered deep-sleep, woke
  logic mode_chg;
  always_comb begin
    mode_chg = mode_nxt != mode_r;
    ev = '0;
    ev[EV_FAULT] = fault_nxt;
    ev[EV_DEEP]  = mode_chg && mode_nxt == MODE_DEEP;
    ev[EV_WAKE]  = mode_chg && mode_nxt == MODE_RUN;
    stat_nxt = (stat_r & ~clr) | ev;
  end

  logic irq_nxt;
  always_comb begin
    irq_nxt = |(stat_nxt & ien_nxt);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unit_ack   <= 1'b0;
      unit_fault <= 1'b0;
      stat_r     <= '0;
      irq        <= 1'b0;
    end else begin
      unit_ack   <= ack_nxt;
      unit_fault <= fault_nxt;
      stat_r     <= stat_nxt;
      irq        <= irq_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_deep_reset: assert property (
    $fell(rst) |-> deep_r == DEEP_RST)
    else $error("deep copy reset value wrong");

  a_gated_fault: assert property (
    unit_req && unit_idx < 3'(UNITS) && !en[unit_idx]
      |=> unit_fault && unit_ack)
    else $error("gated unit access not faulted");

  a_clocked_ok: assert property (
    unit_req && unit_idx < 3'(UNITS) && en[unit_idx]
      |=> unit_ack && !unit_fault)
    else $error("clocked unit access faulted");

  a_wdt_fault: assert property (
    unit_req && unit_idx == U_WDT && !wdt_clk_en |=> unit_fault)
    else $error("watchdog access while off not faulted");

  a_deep_select: assert property (
    mode_r == MODE_DEEP && cfg_r[ACG_BIT]
      |=> hib_clk_en == $past(deep_r[HIB_BIT]))
    else $error("deep copy not applied in deep-sleep");

  a_run_fallback: assert property (
    !cfg_r[ACG_BIT] |=> can_clk_en == $past(run_r[CAN_BIT])
      && wdt_clk_en == $past(run_r[WDT_BIT]))
    else $error("run copy not used without auto gating");

  a_rate_cap: assert property (
    adc_rate <= ADC_RATE_MAX && deep_r[RATE_LSB +: RATE_W] <= ADC_RATE_MAX)
    else $error("ADC rate above maximum");

  a_reserved_zero: assert property (
    (deep_r & ~GATE_MASK) == 32'h0 && (run_r & ~GATE_MASK) == 32'h0)
    else $error("reserved gating bit set");

  a_hib_follow: assert property (
    $rose(hib_clk_en) |-> $past(eff[HIB_BIT]))
    else $error("hibernation enable without its bit");

  a_apb_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("access phase not answered in one wait");

endmodule
`default_nettype wire

// >>> tb/unit_host.sv
`timescale 1ns/1ns
`default_nettype none
module unit_host (
  input  wire logic       ref_clk,
  output logic            unit_req,
  output logic [2:0]      unit_idx
);
  // One-cycle unit access, index scrambled while idle
  task automatic access(input logic [2:0] idx);
    @(posedge ref_clk);
    unit_req <= 1'h1;
    unit_idx <= idx;
    @(posedge ref_clk);
    unit_req <= 1'h0;
    unit_idx <= ~idx;
  endtask

  // Idle at time zero
  initial begin
    unit_req = 1'h0;
    unit_idx = 3'h7;
  end
endmodule
`default_nettype wire

// >>> tb/deep_sleep_gating_tb.sv
`timescale 1ns/1ns
`default_nettype none
module deep_sleep_gating_tb;
  import gate_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, sleep_in, deep_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, unit_req, unit_ack, unit_fault, irq;
  logic [2:0]  unit_idx;
  logic        can_clk_en, pwm_clk_en, adc_clk_en, hib_clk_en, wdt_clk_en;
  logic [3:0]  adc_rate;
  logic [32:0] exp_q[$];
  logic        uq[$];
  int          n_errors, n_checks, cyc;

  deep_sleep_gating i_deep_sleep_gating (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_in(sleep_in), .deep_in(deep_in),
    .unit_req(unit_req), .unit_idx(unit_idx), .unit_ack(unit_ack),
    .unit_fault(unit_fault), .can_clk_en(can_clk_en), .pwm_clk_en(pwm_clk_en),
    .adc_clk_en(adc_clk_en), .hib_clk_en(hib_clk_en), .wdt_clk_en(wdt_clk_en),
    .adc_rate(adc_rate), .irq(irq));
  unit_host i_unit_host (.ref_clk(ref_clk), .unit_req(unit_req), .unit_idx(unit_idx));

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; expected {pslverr, prdata} queued
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Clock enables and rate after they settle
  task lvl(input logic [4:0] en, input logic [3:0] rate);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({can_clk_en, pwm_clk_en, adc_clk_en, hib_clk_en, wdt_clk_en, adc_rate}, {en, rate});
  endtask

  function automatic logic [31:0] gated(input logic [31:0] v);
    gated = v & GATE_MASK;
    if (gated[11:8] > RATE_500K)
      gated[11:8] = RATE_500K;
  endfunction

  // Result watchers
  always @(posedge ref_clk) begin
    if (pready === 1'h1)
      chk({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'hX);
    if (unit_ack === 1'h1)
      chk({32'h0, unit_fault}, {32'h0, uq.size() ? uq.pop_front() : 1'hX});
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report;
    end
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, sleep_in, deep_in} = '0;
    rst = 1'h1;
    void'($urandom(32'hA0E9));
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    apb(1'h0, DEEP_GATING_OFS, 32'h0, {1'h0, DEEP_RST});
    apb(1'h0, RUN_GATING_OFS, 32'h0, 33'h0);
    lvl(5'h00, RATE_125K);
    apb(1'h1, DEEP_GATING_OFS, 32'hFFFF_FFFF, 33'h0);
    apb(1'h0, DEEP_GATING_OFS, 32'h0, {1'h0, 32'h0111_0248});
    apb(1'h1, RUN_GATING_OFS, 32'h0100_0108, 33'h0);
    lvl(5'h11, RATE_250K);
    for (int i = 0; i < 6; i++) begin
      uq.push_back(i > 4 || !(i == 0 || i == 4));
      i_unit_host.access(i[2:0]);
    end
    apb(1'h1, RUN_CLOCK_CONFIG_OFS, 32'h0800_0000, 33'h0);
    deep_in <= 1'h1;
    repeat (4) @(posedge ref_clk);
    lvl(5'h1F, RATE_500K);
    deep_in <= 1'h0;
    sleep_in <= 1'h1;
    repeat (4) @(posedge ref_clk);
    lvl(5'h00, RATE_125K);
    apb(1'h1, RUN_CLOCK_CONFIG_OFS, 32'h0, 33'h0);
    repeat (4) @(posedge ref_clk);
    lvl(5'h11, RATE_250K);
    sleep_in <= 1'h0;
    apb(1'h0, 12'hFFC, 32'h0, {1'h1, 32'h0});
    apb(1'h1, 12'h3F0, 32'h1, {1'h1, 32'h0});
    // Fault event raised, masked and cleared
    apb(1'h1, IRQ_ENABLE_OFS, 32'h1, 33'h0);
    lvl(5'h11, RATE_250K);
    chk(irq, 1'h1);
    apb(1'h1, IRQ_ENABLE_OFS, 32'h0, 33'h0);
    lvl(5'h11, RATE_250K);
    chk(irq, 1'h0);
    apb(1'h1, IRQ_ENABLE_OFS, 32'h1, 33'h0);
    apb(1'h1, IRQ_CLEAR_OFS, 32'h7, 33'h0);
    lvl(5'h11, RATE_250K);
    chk(irq, 1'h0);
    // Random writes to the sleep copy
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      apb(1'h1, SLEEP_GATING_OFS, r, 33'h0);
      apb(1'h0, SLEEP_GATING_OFS, 32'h0, {1'h0, gated(r)});
    end
    repeat (3) @(posedge ref_clk);
    // Every queued answer must have been seen
    chk(exp_q.size(), 0);
    chk(uq.size(), 0);
    final_report;
  end
endmodule
`default_nettype wire
